/* include/astrc_pkg.sv */
// ************************************************************
// Shared constants of the addressable serial port
// ************************************************************
package astrc_pkg;
	// Register offsets
	localparam logic [2:0] ADDR_TX_STATUS = 3'h0;
	localparam logic [2:0] ADDR_RX_STATUS = 3'h1;
	localparam logic [2:0] ADDR_TX_HOLD = 3'h2;
	localparam logic [2:0] ADDR_RX_DATA = 3'h3;
	localparam logic [2:0] ADDR_BAUD_DIV = 3'h4;
	localparam logic [2:0] ADDR_PERIPH_FLAG = 3'h5;
	localparam logic [2:0] ADDR_PERIPH_EN = 3'h6;
	localparam logic [2:0] ADDR_CORE_INT = 3'h7;
	// Transmit status and control fields
	localparam int TXS_NINE_BIT = 6;
	localparam int TXS_TX_EN = 5;
	localparam int TXS_CLOCKED = 4;
	localparam int TXS_HIGH_SPEED = 2;
	localparam int TXS_SHIFTER_EMPTY = 1;
	localparam int TXS_EXTRA_BIT = 0;
	// Receive status fields
	localparam int RXS_PORT_EN = 7;
	localparam int RXS_NINE_BIT = 6;
	localparam int RXS_CONT_RX = 4;
	localparam int RXS_ADDR_DET = 3;
	localparam int RXS_FRAME_ERR = 2;
	localparam int RXS_OVERRUN = 1;
	localparam int RXS_NINTH_BIT = 0;
	// Peripheral flag and enable fields
	localparam int PER_RX = 5;
	localparam int PER_TX = 4;
	// Core interrupt control fields
	localparam int CORE_GLOBAL = 7;
	localparam int CORE_PERIPH = 6;
	// Reset values
	localparam logic [7:0] RST_BAUD_DIV = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Oversampling ticks per bit for high and low speed
	localparam logic [6:0] OVS_HIGH = 7'h10;
	localparam logic [6:0] OVS_LOW = 7'h40;
	// Receive state machine
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} astrc_rx_state_e;
endpackage : astrc_pkg

/* hw/astrc_baud.sv */
`timescale 1ns/1ps
// ************************************************************
// Baud divider: oversample tick and bit tick
// ************************************************************
module astrc_baud
	import astrc_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] divisor,
	input wire logic high_speed,
	output logic os_tick,
	output logic bit_tick
);
	logic [7:0] div_cnt_r;
	logic [6:0] os_cnt_r;
	logic [6:0] ovs;

	assign ovs = high_speed ? OVS_HIGH : OVS_LOW;

	// Oversample tick every divisor+1 clocks
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_cnt_r <= 8'h00;
			os_tick <= 1'b0;
		end
		else
		begin
			os_tick <= (div_cnt_r == divisor);
			div_cnt_r <= (div_cnt_r >= divisor) ? 8'h00 : div_cnt_r + 8'h01;
		end
	end

	// Bit tick every ovs oversample ticks
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			os_cnt_r <= 7'h00;
			bit_tick <= 1'b0;
		end
		else
		begin
			bit_tick <= 1'b0;
			if (os_tick)
			begin
				if (os_cnt_r >= ovs - 7'h01)
				begin
					os_cnt_r <= 7'h00;
					bit_tick <= 1'b1;
				end
				else
					os_cnt_r <= os_cnt_r + 7'h01;
			end
		end
	end
endmodule : astrc_baud

/* hw/astrc_tx_shift.sv */
`timescale 1ns/1ps
// ************************************************************
// Transmit shift register with start and stop framing
// ************************************************************
module astrc_tx_shift
	import astrc_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic bit_tick,
	input wire logic load,
	input wire logic nine,
	input wire logic [8:0] data,
	output logic busy,
	output logic line
);
	logic [9:0] shift_r;
	logic [3:0] left_r;

	// Frame is start, data LSB first, stop; line idles high
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shift_r <= 10'h3ff;
			left_r <= 4'h0;
			busy <= 1'b0;
			line <= 1'b1;
		end
		else if (!enable)
		begin
			left_r <= 4'h0;
			busy <= 1'b0;
			line <= 1'b1;
		end
		else if (load && !busy)
		begin
			shift_r <= nine ? {1'b1, data} : {2'b11, data[7:0]};
			left_r <= nine ? 4'hb : 4'ha;
			busy <= 1'b1;
		end
		else if (busy && bit_tick)
		begin
			if (left_r == 4'h0)
				busy <= 1'b0;
			else
			begin
				left_r <= left_r - 4'h1;
				// First tick sends the start bit, later ticks shift data then stop
				if (left_r != (nine ? 4'hb : 4'ha))
				begin
					line <= shift_r[0];
					shift_r <= {1'b1, shift_r[9:1]};
				end
				else
					line <= 1'b0;
			end
		end
	end
endmodule : astrc_tx_shift

/* hw/astrc_top.sv */
`timescale 1ns/1ps
// What this block does
// - Shifter-empty flag is 1 when transmit shifter idle, 0 once a character loads.
// - Shifter-empty stays 0 until every bit is out or transmit is disabled; software cannot write it.
// - Shifter-empty feeds no interrupt; software polls it.
// - Neither shift register is reachable from the register port.
// - Nine-bit transmit select sends nine data bits, extra bit as MSB.
// - Holding register and extra bit move together into a free shifter.
// - In address-detect mode a ninth bit of 1 marks an address.
// - Setting transmit enable raises the transmit-buffer-ready flag at once.
// - Transmit interrupt when flag, its enable, peripheral and global enables are 1.
// - Writing the holding register starts transmission of that character once the port and async transmit are enabled; clocked mode never sends it.
// - Reception runs only with continuous receive on; nine-bit select takes nine bits.
// - Receive-data flag sets when a character enters the buffer; interrupt if enabled.
// - Receive status shows head character framing error and its ninth bit.
// - Overrun clears only by clearing continuous receive, never by a write.
// - Address detect with nine bits admits only ninth-bit-1 characters.
// - Characters admitted in nine-bit address-detect mode report ninth bit 1.
// - Clearing address detect admits every later character as normal.
module astrc_top
	import astrc_pkg::*;
#(
	parameter int RXBUF_DEPTH = 2
)
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_irq,
	output logic rx_irq
);
	localparam int PW = $clog2(RXBUF_DEPTH);

	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (RXBUF_DEPTH < 2 || (1 << PW) != RXBUF_DEPTH)
	begin : g_depth_check
		$error("RXBUF_DEPTH must be a power of two of at least 2");
	end

	// ************************************************************
	// Declarations
	// ************************************************************
	logic nine_tx_r, tx_en_r, clocked_r, high_speed_r, extra_tx_r;
	logic port_en_r, nine_rx_r, cont_rx_r, addr_det_r;
	logic [7:0] baud_div_r;
	logic tx_ie_r, rx_ie_r, global_ie_r, periph_ie_r;
	logic [7:0] hold_r;
	logic hold9_r, hold_full_r;
	logic tx_load, tx_busy, tx_ready;
	logic os_tick, bit_tick;
	logic rx_s1_r, rx_s2_r;
	astrc_rx_state_e rx_state_r;
	logic [6:0] rx_cnt_r;
	logic [3:0] rx_bits_r;
	logic [8:0] rx_sh_r;
	logic rx_done_r, rx_ferr_r;
	logic [8:0] rx_word_r;
	logic [9:0] rxbuf_mem [RXBUF_DEPTH];
	logic [PW:0] wr_ptr_r, rd_ptr_r;
	logic buf_empty, buf_full, rx_accept, push, pop;
	logic overrun_r;
	logic rx_run;
	logic [6:0] ovs;
	logic [7:0] rd_val;
	logic [9:0] head;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Detects a register access of one kind at one offset
	function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] off);
		hit = strobe && (a == off);
	endfunction : hit

	assign ovs = high_speed_r ? OVS_HIGH : OVS_LOW;
	assign rx_run = port_en_r && cont_rx_r && !overrun_r;
	assign buf_empty = (wr_ptr_r == rd_ptr_r);
	assign buf_full = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) && (wr_ptr_r[PW] != rd_ptr_r[PW]);
	assign head = rxbuf_mem[rd_ptr_r[PW-1:0]];

	// ************************************************************
	// Control registers written by software
	// ************************************************************
	// Transmit control; shifter-empty bit is not writable
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			nine_tx_r <= 1'b0;
			tx_en_r <= 1'b0;
			clocked_r <= 1'b0;
			high_speed_r <= 1'b0;
			extra_tx_r <= 1'b0;
		end
		else if (hit(reg_wr, reg_addr, ADDR_TX_STATUS))
		begin
			nine_tx_r <= reg_wdata[TXS_NINE_BIT];
			tx_en_r <= reg_wdata[TXS_TX_EN];
			clocked_r <= reg_wdata[TXS_CLOCKED];
			high_speed_r <= reg_wdata[TXS_HIGH_SPEED];
			extra_tx_r <= reg_wdata[TXS_EXTRA_BIT];
		end
	end

	// Receive control; error and ninth bits are not writable
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_en_r <= 1'b0;
			nine_rx_r <= 1'b0;
			cont_rx_r <= 1'b0;
			addr_det_r <= 1'b0;
		end
		else if (hit(reg_wr, reg_addr, ADDR_RX_STATUS))
		begin
			port_en_r <= reg_wdata[RXS_PORT_EN];
			nine_rx_r <= reg_wdata[RXS_NINE_BIT];
			cont_rx_r <= reg_wdata[RXS_CONT_RX];
			addr_det_r <= reg_wdata[RXS_ADDR_DET];
		end
	end

	// Baud divisor and interrupt enables
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			baud_div_r <= RST_BAUD_DIV;
			tx_ie_r <= 1'b0;
			rx_ie_r <= 1'b0;
			global_ie_r <= 1'b0;
			periph_ie_r <= 1'b0;
		end
		else
		begin
			if (hit(reg_wr, reg_addr, ADDR_BAUD_DIV))
				baud_div_r <= reg_wdata;
			if (hit(reg_wr, reg_addr, ADDR_PERIPH_EN))
			begin
				tx_ie_r <= reg_wdata[PER_TX];
				rx_ie_r <= reg_wdata[PER_RX];
			end
			if (hit(reg_wr, reg_addr, ADDR_CORE_INT))
			begin
				global_ie_r <= reg_wdata[CORE_GLOBAL];
				periph_ie_r <= reg_wdata[CORE_PERIPH];
			end
		end
	end

	// ************************************************************
	// Baud divider
	// ************************************************************
	astrc_baud u_baud (
		.mclk(mclk),
		.arst_n(arst_n),
		.divisor(baud_div_r),
		.high_speed(high_speed_r),
		.os_tick(os_tick),
		.bit_tick(bit_tick)
	);

	// ************************************************************
	// Transmit holding register
	// ************************************************************
	// Loads go only into an idle shifter of an enabled async port
	assign tx_load = hold_full_r && !tx_busy && tx_en_r && port_en_r && !clocked_r;
	// Buffer-ready follows enable with no delay beyond the flop
	assign tx_ready = tx_en_r && !hold_full_r;

	// Holding register captures data and the extra bit together
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hold_r <= RST_ZERO;
			hold9_r <= 1'b0;
			hold_full_r <= 1'b0;
		end
		else if (hit(reg_wr, reg_addr, ADDR_TX_HOLD))
		begin
			hold_r <= reg_wdata;
			hold9_r <= extra_tx_r;
			hold_full_r <= 1'b1;
		end
		else if (tx_load)
			hold_full_r <= 1'b0;
	end

	astrc_tx_shift u_tx (
		.mclk(mclk),
		.arst_n(arst_n),
		.enable(port_en_r && tx_en_r),
		.bit_tick(bit_tick),
		.load(tx_load),
		.nine(nine_tx_r),
		.data({hold9_r, hold_r}),
		.busy(tx_busy),
		.line(tx_pin)
	);

	// ************************************************************
	// Receive line synchroniser
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
		end
	end

	// ************************************************************
	// Receive shift register and framing
	// ************************************************************
	// Start checked mid-bit, then one sample per bit
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r <= 7'h00;
			rx_bits_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_done_r <= 1'b0;
			rx_ferr_r <= 1'b0;
			rx_word_r <= 9'h000;
		end
		else
		begin
			rx_done_r <= 1'b0;
			if (!rx_run)
				rx_state_r <= RX_IDLE;
			else
			begin
				case (rx_state_r)
					RX_IDLE:
					begin
						rx_cnt_r <= 7'h00;
						if (!rx_s2_r)
							rx_state_r <= RX_START;
					end
					RX_START:
					begin
						if (os_tick)
						begin
							rx_cnt_r <= rx_cnt_r + 7'h01;
							if (rx_cnt_r == (ovs >> 1) - 7'h01)
							begin
								rx_cnt_r <= 7'h00;
								rx_bits_r <= 4'h0;
								rx_state_r <= rx_s2_r ? RX_IDLE : RX_DATA;
							end
						end
					end
					RX_DATA:
					begin
						if (os_tick)
						begin
							rx_cnt_r <= rx_cnt_r + 7'h01;
							if (rx_cnt_r == ovs - 7'h01)
							begin
								rx_cnt_r <= 7'h00;
								rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
								rx_bits_r <= rx_bits_r + 4'h1;
								if (rx_bits_r == (nine_rx_r ? 4'h8 : 4'h7))
									rx_state_r <= RX_STOP;
							end
						end
					end
					RX_STOP:
					begin
						if (os_tick)
						begin
							rx_cnt_r <= rx_cnt_r + 7'h01;
							if (rx_cnt_r == ovs - 7'h01)
							begin
								rx_ferr_r <= !rx_s2_r;
								rx_word_r <= nine_rx_r ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
								rx_done_r <= 1'b1;
								rx_state_r <= RX_IDLE;
							end
						end
					end
					default:
						rx_state_r <= RX_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// Receive buffer and overrun
	// ************************************************************
	// Address filter drops characters whose ninth bit is 0
	assign rx_accept = !(nine_rx_r && addr_det_r && !rx_word_r[8]);
	assign push = rx_done_r && rx_accept && !buf_full;
	assign pop = hit(reg_rd, reg_addr, ADDR_RX_DATA) && !buf_empty;

	// Buffer storage; shift registers stay off the register map
	always_ff @(posedge mclk)
	begin
		if (push)
			rxbuf_mem[wr_ptr_r[PW-1:0]] <= {rx_ferr_r, rx_word_r};
	end

	// Buffer pointers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end

	// Overrun sets on a full buffer; only clearing receive enable clears it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			overrun_r <= 1'b0;
		else if (rx_done_r && rx_accept && buf_full)
			overrun_r <= 1'b1;
		else if (!cont_rx_r)
			overrun_r <= 1'b0;
	end

	// ************************************************************
	// Interrupt requests
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end
		else
		begin
			tx_irq <= tx_ready && tx_ie_r && periph_ie_r && global_ie_r;
			rx_irq <= !buf_empty && rx_ie_r && periph_ie_r && global_ie_r;
		end
	end

	// ************************************************************
	// Register read port
	// ************************************************************
	// Read mux; unmapped bits and offsets read zero
	always_comb
	begin
		rd_val = 8'h00;
		case (reg_addr)
			ADDR_TX_STATUS:
			begin
				rd_val[TXS_NINE_BIT] = nine_tx_r;
				rd_val[TXS_TX_EN] = tx_en_r;
				rd_val[TXS_CLOCKED] = clocked_r;
				rd_val[TXS_HIGH_SPEED] = high_speed_r;
				rd_val[TXS_SHIFTER_EMPTY] = !tx_busy;
				rd_val[TXS_EXTRA_BIT] = extra_tx_r;
			end
			ADDR_RX_STATUS:
			begin
				rd_val[RXS_PORT_EN] = port_en_r;
				rd_val[RXS_NINE_BIT] = nine_rx_r;
				rd_val[RXS_CONT_RX] = cont_rx_r;
				rd_val[RXS_ADDR_DET] = addr_det_r;
				rd_val[RXS_FRAME_ERR] = !buf_empty && head[9];
				rd_val[RXS_OVERRUN] = overrun_r;
				rd_val[RXS_NINTH_BIT] = !buf_empty && nine_rx_r && head[8];
			end
			ADDR_RX_DATA:
				rd_val = buf_empty ? 8'h00 : head[7:0];
			ADDR_BAUD_DIV:
				rd_val = baud_div_r;
			ADDR_PERIPH_FLAG:
			begin
				rd_val[PER_RX] = !buf_empty;
				rd_val[PER_TX] = tx_ready;
			end
			ADDR_PERIPH_EN:
			begin
				rd_val[PER_RX] = rx_ie_r;
				rd_val[PER_TX] = tx_ie_r;
			end
			ADDR_CORE_INT:
			begin
				rd_val[CORE_GLOBAL] = global_ie_r;
				rd_val[CORE_PERIPH] = periph_ie_r;
			end
			default:
				rd_val = 8'h00;
		endcase
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_val : 8'h00;
	end
endmodule : astrc_top

/* bench/astrc_top_sva.sv */
`timescale 1ns/1ps
// ************************************************************
// Port-level checks of the serial port
// ************************************************************
module astrc_chk
	import astrc_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	logic [7:0] tsc_r;
	logic [7:0] pen_r;
	logic [7:0] core_r;
	logic tx_allow;
	logic rx_allow;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	// Shadow copies of the control bytes written by software
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tsc_r <= 8'h00;
			pen_r <= 8'h00;
			core_r <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == ADDR_TX_STATUS)
				tsc_r <= reg_wdata;
			if (reg_addr == ADDR_PERIPH_EN)
				pen_r <= reg_wdata;
			if (reg_addr == ADDR_CORE_INT)
				core_r <= reg_wdata;
		end
	end
	// Interrupt paths allowed by the enables
	assign tx_allow = tsc_r[TXS_TX_EN] & pen_r[PER_TX] & core_r[CORE_GLOBAL] & core_r[CORE_PERIPH];
	assign rx_allow = pen_r[PER_RX] & core_r[CORE_GLOBAL] & core_r[CORE_PERIPH];
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_hold_reads_zero: assert property (reg_rd && reg_addr == ADDR_TX_HOLD |=> reg_rdata == 8'h00)
		else $error("holding register readable");
	a_flag_spare_zero: assert property (reg_rd && reg_addr == ADDR_PERIPH_FLAG |=> reg_rdata[3:0] == 4'h0)
		else $error("spare flag bits set");
	a_txirq_cause: assert property (tx_irq |-> $past(tx_allow))
		else $error("transmit irq without enables");
	a_rxirq_cause: assert property (rx_irq |-> $past(rx_allow))
		else $error("receive irq without enables");
	a_transmit_enable_irq: assert property (reg_wr && reg_addr == ADDR_TX_STATUS && reg_wdata[TXS_TX_EN]
		&& !reg_wdata[TXS_CLOCKED] && !tsc_r[TXS_TX_EN] && pen_r[PER_TX] && core_r[CORE_GLOBAL]
		&& core_r[CORE_PERIPH] |-> ##[1:3] tx_irq)
		else $error("transmit enable gave no irq");
	a_tx_idle_high: assert property (!$past(tsc_r[TXS_TX_EN]) && !$past(tsc_r[TXS_TX_EN], 2) |-> tx_pin)
		else $error("line not idle high");
	a_low_bit_len: assert property ($fell(tx_pin) |-> !tx_pin [*8])
		else $error("low bit too short");
	a_high_bit_len: assert property ($rose(tx_pin) |-> tx_pin [*8])
		else $error("high bit too short");
	// Main scenarios reached
	c_tx_irq: cover property ($rose(tx_irq));
	c_rx_irq: cover property ($rose(rx_irq));
	c_tx_frame: cover property ($fell(tx_pin));
endmodule : astrc_chk

bind astrc_top astrc_chk i_chk (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
	.tx_irq(tx_irq), .rx_irq(rx_irq));

/* bench/astrc_node.sv */
`timescale 1ns/1ps
// ************************************************************
// Remote serial node on the far end of the line
// ************************************************************
module astrc_node
#(
	parameter int BIT = 16
)
(
	input wire logic mclk,
	input wire logic tx_pin,
	output logic rx_pin
);
	int rx_bits = 8;
	logic [9:0] got_q[$];
	initial rx_pin = 1'b1;
	// Send one frame: low start, data LSB first, high stop
	task automatic send(input logic [8:0] d, input int n);
		for (int i = 0; i < n + 2; i++)
		begin
			@(posedge mclk);
			rx_pin <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i - 1];
			repeat (BIT - 1) @(posedge mclk);
		end
	endtask : send
	// Sample each received bit mid-cell, stop bit stored above the data
	always
	begin : rx_proc
		logic [9:0] v;
		@(negedge tx_pin);
		repeat (BIT / 2) @(posedge mclk);
		v = 10'h000;
		for (int i = 0; i <= rx_bits; i++)
		begin
			repeat (BIT) @(posedge mclk);
			v[i] = tx_pin;
		end
		got_q.push_back(v);
	end
endmodule : astrc_node

/* bench/astrc_top_tb.sv */
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the serial port
// ************************************************************
module astrc_top_tb
	import astrc_pkg::*;
;
	logic mclk, arst_n, reg_wr, reg_rd, rx_pin, tx_pin, tx_irq, rx_irq;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	astrc_top #(.RXBUF_DEPTH(2)) i_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
	astrc_node #(.BIT(16)) i_node (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
	// Clock and hang guard
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			end_sim();
		end
	end
	// ************************************************************
	// Bus and compare helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(nm, {2'b00, rv}, {2'b00, e});
	endtask : rdchk
	task automatic wait_rx(input logic e, input int n);
		int k;
		k = 0;
		while (rx_irq !== e && k < n)
		begin
			@(posedge mclk);
			#1 k++;
		end
		chk("rx_irq", {9'h000, rx_irq}, {9'h000, e});
	endtask : wait_rx
	task automatic wait_tx(input int n, input int lim);
		int k;
		k = 0;
		while (i_node.got_q.size() < n && k < lim)
		begin
			@(posedge mclk);
			k++;
		end
	endtask : wait_tx
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		for (int a = 0; a < 8; a++)
			rdchk(a[2:0], (a == 0) ? 8'h02 : 8'h00, "reset value");
	endtask : t_reset
	task automatic t_tx_enable();
		wr(ADDR_BAUD_DIV, 8'h00);
		wr(ADDR_CORE_INT, 8'hc0);
		wr(ADDR_PERIPH_EN, 8'h30);
		wr(ADDR_RX_STATUS, 8'h80);
		chk("tx_irq off", {9'h000, tx_irq}, 10'h000);
		wr(ADDR_TX_STATUS, 8'h24);
		repeat (3) @(posedge mclk);
		#1 chk("tx_irq on", {9'h000, tx_irq}, 10'h001);
		rdchk(ADDR_PERIPH_FLAG, 8'h10, "tx ready flag");
		wr(ADDR_CORE_INT, 8'h80);
		repeat (3) @(posedge mclk);
		#1 chk("tx_irq masked", {9'h000, tx_irq}, 10'h000);
		wr(ADDR_CORE_INT, 8'hc0);
	endtask : t_tx_enable
	task automatic t_tx8();
		wr(ADDR_TX_HOLD, 8'ha5);
		rdchk(ADDR_TX_STATUS, 8'h24, "shifter busy");
		wr(ADDR_TX_STATUS, 8'h24);
		wait_tx(1, 400);
		rdchk(ADDR_TX_STATUS, 8'h24, "shifter busy to stop");
		repeat (20) @(posedge mclk);
		rdchk(ADDR_TX_STATUS, 8'h26, "shifter empty");
		chk("tx frame 8", i_node.got_q.pop_front(), 10'h1a5);
	endtask : t_tx8
	task automatic t_tx9();
		i_node.rx_bits = 9;
		wr(ADDR_TX_STATUS, 8'h65);
		wr(ADDR_TX_HOLD, 8'h3c);
		wr(ADDR_TX_STATUS, 8'h64);
		wr(ADDR_TX_HOLD, 8'h0f);
		wait_tx(2, 800);
		chk("tx frame 9 a", i_node.got_q.pop_front(), 10'h33c);
		chk("tx frame 9 b", i_node.got_q.pop_front(), 10'h20f);
	endtask : t_tx9
	task automatic t_rx8();
		wr(ADDR_RX_STATUS, 8'h90);
		i_node.send(9'h05a, 8);
		wait_rx(1'b1, 60);
		rdchk(ADDR_PERIPH_FLAG, 8'h30, "rx avail flag");
		rdchk(ADDR_RX_STATUS, 8'h90, "rx status");
		rdchk(ADDR_RX_DATA, 8'h5a, "rx data");
		wait_rx(1'b0, 4);
	endtask : t_rx8
	task automatic t_rx_addr();
		wr(ADDR_RX_STATUS, 8'hd8);
		i_node.send(9'h0aa, 9);
		repeat (40) @(posedge mclk);
		#1 chk("data dropped", {9'h000, rx_irq}, 10'h000);
		i_node.send(9'h1c3, 9);
		wait_rx(1'b1, 60);
		rdchk(ADDR_RX_STATUS, 8'hd9, "addr ninth bit");
		rdchk(ADDR_RX_DATA, 8'hc3, "addr data");
		wr(ADDR_RX_STATUS, 8'hd0);
		i_node.send(9'h044, 9);
		wait_rx(1'b1, 60);
		rdchk(ADDR_RX_STATUS, 8'hd0, "data ninth bit");
		rdchk(ADDR_RX_DATA, 8'h44, "data after addr");
	endtask : t_rx_addr
	task automatic t_overrun();
		wr(ADDR_RX_STATUS, 8'h90);
		i_node.send(9'h011, 8);
		i_node.send(9'h022, 8);
		i_node.send(9'h033, 8);
		repeat (20) @(posedge mclk);
		rdchk(ADDR_RX_STATUS, 8'h92, "overrun set");
		wr(ADDR_RX_STATUS, 8'h90);
		rdchk(ADDR_RX_STATUS, 8'h92, "overrun kept");
		rdchk(ADDR_RX_DATA, 8'h11, "first kept");
		rdchk(ADDR_RX_DATA, 8'h22, "second kept");
		wr(ADDR_RX_STATUS, 8'h80);
		rdchk(ADDR_RX_STATUS, 8'h80, "overrun cleared");
		i_node.send(9'h077, 8);
		repeat (40) @(posedge mclk);
		#1 chk("rx off irq", {9'h000, rx_irq}, 10'h000);
		rdchk(ADDR_PERIPH_FLAG, 8'h10, "rx off flag");
	endtask : t_overrun
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// Reset, then each scenario in turn
	initial
	begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_tx_enable();
		t_tx8();
		t_tx9();
		t_rx8();
		t_rx_addr();
		t_overrun();
		end_sim();
	end
endmodule : astrc_top_tb
